// ### rtl/udfc_pkg.sv
package udfc_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned FUNC_W = 6;

   // ****************************************************************
   // Terminal function codes
   // ****************************************************************
   localparam logic [5:0] FUNC_NONE = 6'h00;
   localparam logic [5:0] FUNC_UP   = 6'h11;
   localparam logic [5:0] FUNC_DOWN = 6'h12;
   localparam logic [5:0] FUNC_CLR  = 6'h14;
   localparam logic [5:0] FUNC_EN   = 6'h1b;

   // ****************************************************************
   // Register word addresses
   // ****************************************************************
   localparam logic [3:0] ADDR_FUNC0 = 4'h0;
   localparam logic [3:0] ADDR_CTRL  = 4'h8;
   localparam logic [3:0] ADDR_MAXF  = 4'h9;
   localparam logic [3:0] ADDR_STEP  = 4'ha;
   localparam logic [3:0] ADDR_STAT  = 4'hb;
   localparam logic [3:0] ADDR_SAVED = 4'hc;
   localparam logic [3:0] ADDR_FREQ  = 4'hd;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int unsigned CTRL_SAVE_BIT = 0;
   localparam int unsigned STAT_UD_BIT   = 0;
   localparam int unsigned STAT_ENA_BIT  = 1;
   localparam int unsigned STAT_RUN_BIT  = 2;
   localparam logic        SAVE_EN_RST   = 1'b1;
   localparam logic [15:0] MAXF_RST      = 16'h1770;
   localparam logic [15:0] STEP_RST      = 16'h000a;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS    = 10;
   localparam int unsigned RAMP_TICK_NS     = 1000000;
   localparam int unsigned RAMP_TICK_CYCLES = RAMP_TICK_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      RM_HOLD,
      RM_UP,
      RM_DOWN,
      RM_TRACK,
      RM_LOAD
   } udfc_rmode_t;

endpackage : udfc_pkg

// ### rtl/udfc_ramp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface udfc_ramp_if #(
   parameter int unsigned FREQ_W = 16
);
   udfc_pkg::udfc_rmode_t mode;
   logic [FREQ_W-1:0]     target;
   logic [FREQ_W-1:0]     load_val;
   logic [FREQ_W-1:0]     max_freq;
   logic [FREQ_W-1:0]     step;
   logic [FREQ_W-1:0]     freq;

   modport ctrl (output mode, target, load_val, max_freq, step, input freq);
   modport ramp (input mode, target, load_val, max_freq, step, output freq);
endinterface : udfc_ramp_if
`default_nettype wire

// ### rtl/udfc_ramp.sv
`timescale 1ns/100ps
`default_nettype none
module udfc_ramp #(
   parameter int unsigned FREQ_W   = 16,
   parameter int unsigned TICK_DIV = udfc_pkg::RAMP_TICK_CYCLES
) (
   input wire logic clk_i,       // System clock.
   input wire logic rst_n_i,     // Synchronous reset, active low.
   udfc_ramp_if.ramp rif         // Ramp control from the terminal logic.
);

   localparam int unsigned CNT_W = $clog2(TICK_DIV);

   if (TICK_DIV < 2) begin : g_chk
      $error("udfc_ramp: TICK_DIV must be at least 2");
   end

   typedef struct packed {
      logic [CNT_W-1:0]  cnt;
      logic [FREQ_W-1:0] freq;
   } udfc_ramp_st_t;

   udfc_ramp_st_t s_r;
   udfc_ramp_st_t s_nxt;

   // ****************************************************************
   // Step generator
   // ****************************************************************
   // The ramp moves one step per tick; a load bypasses the tick so that
   // a resumed or cleared frequency appears at once.
   always_comb begin
      logic              tick;
      logic [FREQ_W:0]   sum;
      logic [FREQ_W-1:0] upv;
      logic [FREQ_W-1:0] dnv;
      logic [FREQ_W-1:0] tgt;
      tick  = 1'b0;
      sum   = '0;
      upv   = '0;
      dnv   = '0;
      tgt   = '0;
      s_nxt = s_r;
      if (s_r.cnt == CNT_W'(TICK_DIV - 1)) begin
         s_nxt.cnt = '0;
         tick      = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end
      sum = {1'b0, s_r.freq} + {1'b0, rif.step};
      upv = (sum > {1'b0, rif.max_freq}) ? rif.max_freq : sum[FREQ_W-1:0];   // [R13]
      dnv = (s_r.freq > rif.step) ? (s_r.freq - rif.step) : '0;              // [R13]
      tgt = (rif.target > rif.max_freq) ? rif.max_freq : rif.target;
      case (rif.mode)
         udfc_pkg::RM_LOAD: begin
            s_nxt.freq = (rif.load_val > rif.max_freq) ? rif.max_freq : rif.load_val;
         end
         udfc_pkg::RM_UP: begin
            if (tick) begin
               s_nxt.freq = upv;                                             // [R7]
            end
         end
         udfc_pkg::RM_DOWN: begin
            if (tick) begin
               s_nxt.freq = dnv;                                             // [R8]
            end
         end
         udfc_pkg::RM_TRACK: begin
            if (tick && (s_r.freq < tgt)) begin
               s_nxt.freq = (upv > tgt) ? tgt : upv;                         // [R5]
            end else if (tick && (s_r.freq > tgt)) begin
               s_nxt.freq = (dnv < tgt) ? tgt : dnv;                         // [R5]
            end
         end
         default: begin
            s_nxt.freq = s_r.freq;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rif.freq = s_r.freq;

endmodule : udfc_ramp
`default_nettype wire

// ### rtl/udfc_top.sv
// Behaviour
// (R1) Each input terminal takes function code 17 up, 18 down, 27 switchover.
// (R2) Switchover assigned and inactive: follow analog input, ignore up and down.
// (R3) Switchover active: only up and down steer frequency, analog ignored.
// (R4) No switchover terminal assigned: only up and down change frequency.
// (R5) Without switchover the frequency ramps normally toward the run target.
// (R6) Switchover arriving mid-ramp halts the ramp and holds frequency.
// (R7) Run with up-down active: up accelerates, release holds reached frequency.
// (R8) Down decelerates, release holds reached frequency.
// (R9) Up and down together: stop ramping and hold present frequency.
// (R10) With saving on, store frequency at run removal, trip or power loss.
// (R11) On run return, power restore or trip recovery resume stored frequency.
// (R12) Code 20 terminal during up-down operation clears stored frequency.
// (R13) Up-down frequency stays between zero and configured maximum.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module udfc_top #(
   parameter int unsigned FREQ_W      = 16,
   parameter int unsigned TERM_N      = 5,
   parameter int unsigned TICK_CYCLES = udfc_pkg::RAMP_TICK_CYCLES
) (
   input  wire logic                            clk_i,                  // System clock.
   input  wire logic                            rst_n_i,                // Sync reset, low.
   input  wire logic [TERM_N-1:0]               multi_function_input_i, // Terminals, high on.
   input  wire logic                            forward_run_command_i,  // Run command.
   input  wire logic                            fault_trip_i,           // Fault trip level.
   input  wire logic                            power_loss_i,           // Power loss level.
   input  wire logic [FREQ_W-1:0]               analog_voltage_input_i, // Analog frequency.
   input  wire logic [udfc_pkg::ADDR_W-1:0]     addr_i,                 // Register address.
   input  wire logic [udfc_pkg::DATA_W-1:0]     wr_data_i,              // Write data.
   input  wire logic                            wr_i,                   // Write strobe.
   input  wire logic                            rd_i,                   // Read strobe.
   output logic      [udfc_pkg::DATA_W-1:0]     rd_data_o,              // Read data.
   output logic      [FREQ_W-1:0]               cmd_freq_o,             // Command frequency.
   output logic                                 ud_active_o             // Up-down in control.
);

   localparam int unsigned FW = udfc_pkg::FUNC_W;
   localparam int unsigned DW = udfc_pkg::DATA_W;

   if ((TERM_N < 1) || (TERM_N > 8) || (FREQ_W < 8) || (FREQ_W > 32)) begin : g_chk
      $error("udfc_top: TERM_N must be 1..8 and FREQ_W 8..32");
   end

   typedef struct packed {
      logic [TERM_N-1:0][FW-1:0] func;
      logic                      save_en;
      logic [FREQ_W-1:0]         max_freq;
      logic [FREQ_W-1:0]         step;
      logic [FREQ_W-1:0]         saved;
      logic [FREQ_W-1:0]         cmd_freq;
      logic                      run_q;
      logic                      ud_act;
      logic [DW-1:0]             rd_data;
   } udfc_st_t;

   udfc_st_t s_r;
   udfc_st_t s_nxt;

   udfc_ramp_if #(.FREQ_W(FREQ_W)) rif ();

   udfc_ramp #(
      .FREQ_W   (FREQ_W),
      .TICK_DIV (TICK_CYCLES)
   ) u_ramp (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .rif     (rif.ramp)
   );

   // ****************************************************************
   // Terminal decode
   // ****************************************************************
   logic [TERM_N-1:0] up_vec;
   logic [TERM_N-1:0] dn_vec;
   logic [TERM_N-1:0] en_vec;
   logic [TERM_N-1:0] en_asg_vec;
   logic [TERM_N-1:0] clr_vec;

   for (genvar i = 0; i < TERM_N; i++) begin : g_term
      logic on;
      assign on            = multi_function_input_i[i];
      assign up_vec[i]     = on && (s_r.func[i] == udfc_pkg::FUNC_UP);          // [R1]
      assign dn_vec[i]     = on && (s_r.func[i] == udfc_pkg::FUNC_DOWN);        // [R1]
      assign en_vec[i]     = on && (s_r.func[i] == udfc_pkg::FUNC_EN);          // [R1]
      assign en_asg_vec[i] = (s_r.func[i] == udfc_pkg::FUNC_EN);                // [R1]
      assign clr_vec[i]    = on && (s_r.func[i] == udfc_pkg::FUNC_CLR);         // [R12]
   end

   logic up_hit;
   logic dn_hit;
   logic en_asg;
   logic ud_mode;
   logic run_now;
   logic save_evt;
   logic resume_evt;
   logic clr_evt;

   assign up_hit     = |up_vec;
   assign dn_hit     = |dn_vec;
   assign en_asg     = |en_asg_vec;
   // Without a switchover terminal the block stays in up-down control for good.
   assign ud_mode    = en_asg ? (|en_vec) : 1'b1;                             // [R2] [R3] [R4]
   // A trip or power loss takes the run away just like removing the command.
   assign run_now    = forward_run_command_i && !fault_trip_i && !power_loss_i;
   assign save_evt   = s_r.save_en && s_r.run_q && !run_now;                  // [R10]
   assign resume_evt = s_r.save_en && !s_r.run_q && run_now && ud_mode;       // [R11]
   assign clr_evt    = (|clr_vec) && ud_mode;                                 // [R12]

   // ****************************************************************
   // Ramp control
   // ****************************************************************
   always_comb begin
      rif.mode     = udfc_pkg::RM_HOLD;
      rif.target   = '0;
      rif.load_val = '0;
      rif.max_freq = s_r.max_freq;
      rif.step     = s_r.step;
      if (clr_evt) begin
         rif.mode = udfc_pkg::RM_LOAD;                                        // [R12]
      end else if (resume_evt) begin
         rif.mode     = udfc_pkg::RM_LOAD;                                    // [R11]
         rif.load_val = s_r.saved;
      end else if (!run_now) begin
         rif.mode = udfc_pkg::RM_TRACK;
      end else if (!ud_mode) begin
         rif.mode   = udfc_pkg::RM_TRACK;                                     // [R2] [R5]
         rif.target = analog_voltage_input_i;
      end else if (up_hit && !dn_hit) begin
         rif.mode = udfc_pkg::RM_UP;                                          // [R7]
      end else if (dn_hit && !up_hit) begin
         rif.mode = udfc_pkg::RM_DOWN;                                        // [R8]
      end else begin
         rif.mode = udfc_pkg::RM_HOLD;                                        // [R3] [R6] [R9]
      end
   end

   // ****************************************************************
   // Registers and state
   // ****************************************************************
   always_comb begin
      logic [DW-1:0] rdv;
      rdv          = '0;
      s_nxt        = s_r;
      s_nxt.run_q  = run_now;
      s_nxt.cmd_freq = rif.freq;
      s_nxt.ud_act = ud_mode && run_now;
      if (save_evt) begin
         s_nxt.saved = rif.freq;                                              // [R10]
      end
      if (clr_evt) begin
         s_nxt.saved = '0;                                                    // [R12]
      end
      if (wr_i) begin
         for (int i = 0; i < TERM_N; i++) begin
            if (addr_i == (udfc_pkg::ADDR_FUNC0 + udfc_pkg::ADDR_W'(i))) begin
               s_nxt.func[i] = wr_data_i[FW-1:0];                             // [R1]
            end
         end
         case (addr_i)
            udfc_pkg::ADDR_CTRL: s_nxt.save_en = wr_data_i[udfc_pkg::CTRL_SAVE_BIT];
            udfc_pkg::ADDR_MAXF: s_nxt.max_freq = wr_data_i[FREQ_W-1:0];
            udfc_pkg::ADDR_STEP: s_nxt.step = wr_data_i[FREQ_W-1:0];
            default: begin
            end
         endcase
      end
      if (rd_i) begin
         for (int i = 0; i < TERM_N; i++) begin
            if (addr_i == (udfc_pkg::ADDR_FUNC0 + udfc_pkg::ADDR_W'(i))) begin
               rdv = DW'(s_r.func[i]);
            end
         end
         case (addr_i)
            udfc_pkg::ADDR_CTRL: rdv[udfc_pkg::CTRL_SAVE_BIT] = s_r.save_en;
            udfc_pkg::ADDR_MAXF: rdv = DW'(s_r.max_freq);
            udfc_pkg::ADDR_STEP: rdv = DW'(s_r.step);
            udfc_pkg::ADDR_STAT: begin
               rdv[udfc_pkg::STAT_UD_BIT]  = ud_mode;
               rdv[udfc_pkg::STAT_ENA_BIT] = en_asg;
               rdv[udfc_pkg::STAT_RUN_BIT] = run_now;
            end
            udfc_pkg::ADDR_SAVED: rdv = DW'(s_r.saved);
            udfc_pkg::ADDR_FREQ: rdv = DW'(rif.freq);
            default: begin
            end
         endcase
      end
      s_nxt.rd_data = rdv;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_r          <= '0;
         s_r.save_en  <= udfc_pkg::SAVE_EN_RST;
         s_r.max_freq <= FREQ_W'(udfc_pkg::MAXF_RST);
         s_r.step     <= FREQ_W'(udfc_pkg::STEP_RST);
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rd_data_o   = s_r.rd_data;
   assign cmd_freq_o  = s_r.cmd_freq;
   assign ud_active_o = s_r.ud_act;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_up_rise;
      @(posedge clk_i) disable iff (!rst_n_i)
      (rif.mode == udfc_pkg::RM_UP) |=> (rif.freq >= $past(rif.freq));
   endproperty
   a_up_rise: assert property (p_up_rise) else $error("Up did not raise"); // [R1] [R7]

   property p_analog_follow;
      @(posedge clk_i) disable iff (!rst_n_i)
      (run_now && en_asg && !(|en_vec)) |->
         (rif.mode == udfc_pkg::RM_TRACK) && (rif.target == analog_voltage_input_i) ||
         clr_evt || resume_evt;
   endproperty
   a_analog_follow: assert property (p_analog_follow) else $error("Analog ignored"); // [R2]

   property p_ud_only;
      @(posedge clk_i) disable iff (!rst_n_i)
      (run_now && (|en_vec)) |-> (rif.mode != udfc_pkg::RM_TRACK);
   endproperty
   a_ud_only: assert property (p_ud_only) else $error("Analog used in up-down"); // [R3]

   property p_no_enable;
      @(posedge clk_i) disable iff (!rst_n_i)
      !en_asg |-> ud_mode;
   endproperty
   a_no_enable: assert property (p_no_enable) else $error("Up-down left"); // [R4]

   property p_track_dir;
      @(posedge clk_i) disable iff (!rst_n_i)
      ((rif.mode == udfc_pkg::RM_TRACK) && (rif.freq <= rif.target) &&
       (rif.target <= s_r.max_freq)) |=> (rif.freq >= $past(rif.freq));
   endproperty
   a_track_dir: assert property (p_track_dir) else $error("Ramp wrong way"); // [R5]

   property p_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
      (run_now && ud_mode && (up_hit == dn_hit) && !clr_evt && !resume_evt)
         |=> (rif.freq == $past(rif.freq));
   endproperty
   a_hold: assert property (p_hold) else $error("Hold lost"); // [R6] [R9]

   property p_down_fall;
      @(posedge clk_i) disable iff (!rst_n_i)
      (rif.mode == udfc_pkg::RM_DOWN) |=> (rif.freq <= $past(rif.freq));
   endproperty
   a_down_fall: assert property (p_down_fall) else $error("Down did not lower"); // [R8]

   property p_save;
      @(posedge clk_i) disable iff (!rst_n_i)
      (save_evt && !clr_evt) |=> (s_r.saved == $past(rif.freq));
   endproperty
   a_save: assert property (p_save) else $error("Frequency not saved"); // [R10]

   property p_resume;
      @(posedge clk_i) disable iff (!rst_n_i)
      (resume_evt && !clr_evt && (s_r.saved <= s_r.max_freq)) |=>
         (rif.freq == $past(s_r.saved));
   endproperty
   a_resume: assert property (p_resume) else $error("Resume missed"); // [R11]

   property p_clear;
      @(posedge clk_i) disable iff (!rst_n_i)
      clr_evt |=> (s_r.saved == '0) && (rif.freq == '0);
   endproperty
   a_clear: assert property (p_clear) else $error("Clear missed"); // [R12]

   property p_limit;
      @(posedge clk_i) disable iff (!rst_n_i)
      (rif.mode == udfc_pkg::RM_UP) |=> (rif.freq <= $past(s_r.max_freq));
   endproperty
   a_limit: assert property (p_limit) else $error("Above maximum"); // [R13]

   // The status output must agree with who steers the frequency, or an operator
   // could believe the terminals are live while the analog input is in charge.
   property p_ud_flag_on;
      @(posedge clk_i) disable iff (!rst_n_i)
      (run_now && (|en_vec)) |=> s_r.ud_act;
   endproperty
   a_ud_flag_on: assert property (p_ud_flag_on) else $error("Up-down flag low"); // [R3]

   property p_ud_flag_off;
      @(posedge clk_i) disable iff (!rst_n_i)
      (run_now && en_asg && !(|en_vec)) |=> !s_r.ud_act;
   endproperty
   a_ud_flag_off: assert property (p_ud_flag_off) else $error("Up-down flag high"); // [R2]

   property p_normal_no_up;
      @(posedge clk_i) disable iff (!rst_n_i)
      (run_now && !ud_mode && up_hit && !clr_evt && !resume_evt &&
       (rif.freq >= rif.target)) |=> (rif.freq <= $past(rif.freq));
   endproperty
   a_normal_no_up: assert property (p_normal_no_up) else $error("Up obeyed in normal"); // [R2]

   property p_track_down;
      @(posedge clk_i) disable iff (!rst_n_i)
      ((rif.mode == udfc_pkg::RM_TRACK) && (rif.freq >= rif.target))
         |=> (rif.freq <= $past(rif.freq));
   endproperty
   a_track_down: assert property (p_track_down) else $error("Ramp rose past target"); // [R5]

endmodule : udfc_top
`default_nettype wire

// ### verification/udfc_switch_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Terminal contacts
// ****************************************************************
// A switch or limit contact gives a clean level one clock after it is
// thrown. Contact bounce is left out, because the terminal logic samples
// levels and has no debounce of its own to test.
module udfc_switch_model #(
   parameter int unsigned TERM_N = 5
) (
   input  wire logic              clk_i,   // System clock.
   input  wire logic [TERM_N-1:0] press_i, // Operator throws contacts.
   output logic      [TERM_N-1:0] term_o   // Terminal levels, high on.
);
   always_ff @(posedge clk_i) begin
      term_o <= press_i;
   end
endmodule : udfc_switch_model
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam int unsigned TN = 5;
   localparam logic [31:0] MAXV = 32'h00000300;
   logic        clk_i   = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [4:0]  press   = 5'h00;
   logic [4:0]  term;
   logic [2:0]  ev      = 3'h0;
   logic [15:0] ana     = 16'h0000;
   logic [3:0]  addr    = 4'h0;
   logic [31:0] wdat    = 32'h00000000;
   logic        wr      = 1'b0;
   logic        rd      = 1'b0;
   logic [31:0] rdat;
   logic [15:0] cmd_freq;
   logic        ud_act;
   logic [31:0] d;
   logic [31:0] v;
   int          fail_count = 0;
   int          cmp_count  = 0;

   always #5 clk_i = ~clk_i;

   udfc_switch_model #(.TERM_N(TN)) sw (.clk_i(clk_i), .press_i(press), .term_o(term));

   udfc_top #(.FREQ_W(16), .TERM_N(TN), .TICK_CYCLES(4)) dut (
      .clk_i                  (clk_i),
      .rst_n_i                (rst_n_i),
      .multi_function_input_i (term),
      .forward_run_command_i  (~ev[0]),
      .fault_trip_i           (ev[1]),
      .power_loss_i           (ev[2]),
      .analog_voltage_input_i (ana),
      .addr_i                 (addr),
      .wr_data_i              (wdat),
      .wr_i                   (wr),
      .rd_i                   (rd),
      .rd_data_o              (rdat),
      .cmd_freq_o             (cmd_freq),
      .ud_active_o            (ud_act)
   );

   // ****************************************************************
   // Access and compare tasks
   // ****************************************************************
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wt

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] x);
      @(posedge clk_i);
      addr <= a;
      wdat <= x;
      wr   <= 1'b1;
      @(posedge clk_i);
      wr   <= 1'b0;
   endtask : reg_wr

   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] x);
      @(posedge clk_i);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_i);
      rd   <= 1'b0;
      #1 x = rdat;
   endtask : reg_rd

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      reg_rd(a, d);
      chk(d, exp);
   endtask : rd_chk

   task automatic freq_chk(input logic [31:0] exp);
      #1 chk({16'h0000, cmd_freq}, exp);
   endtask : freq_chk

   task automatic push(input logic [4:0] p, input int n);
      @(posedge clk_i) press <= p;
      wt(n);
   endtask : push

   // Hangs are cut short here; every other wait is a fixed count.
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      end_of_test();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      wt(20);
      @(posedge clk_i) rst_n_i <= 1'b1;
      rd_chk(udfc_pkg::ADDR_MAXF, 32'h00001770);
      rd_chk(udfc_pkg::ADDR_STEP, 32'h0000000a);
      rd_chk(udfc_pkg::ADDR_CTRL, 32'h00000001);
      rd_chk(udfc_pkg::ADDR_SAVED, 32'h00000000);
      reg_wr(4'hf, 32'h0000ffff);
      rd_chk(4'hf, 32'h00000000);
      // Terminals 0..3 become up, down, clear and switchover.
      reg_wr(udfc_pkg::ADDR_FUNC0, 32'h00000011);
      reg_wr(udfc_pkg::ADDR_FUNC0 + 4'h1, 32'h00000012);
      reg_wr(udfc_pkg::ADDR_FUNC0 + 4'h2, 32'h00000014);
      reg_wr(udfc_pkg::ADDR_FUNC0 + 4'h3, 32'h0000001b);
      rd_chk(udfc_pkg::ADDR_FUNC0 + 4'h3, 32'h0000001b);
      reg_wr(udfc_pkg::ADDR_MAXF, MAXV);
      reg_wr(udfc_pkg::ADDR_STEP, 32'h00000064);
      @(posedge clk_i) ana <= 16'h00c8;
      push(5'h01, 60);
      freq_chk(32'h000000c8);
      rd_chk(udfc_pkg::ADDR_STAT, 32'h00000006);
      chk({31'h0, ud_act}, 32'h00000000);
      // Switchover mid-ramp: the ramp stops where it stands.
      @(posedge clk_i) ana <= 16'h0320;
      push(5'h00, 9);
      push(5'h08, 4);
      reg_rd(udfc_pkg::ADDR_FREQ, v);
      chk({31'h0, ud_act}, 32'h00000001);
      @(posedge clk_i) ana <= 16'h0000;
      wt(40);
      freq_chk(v);
      chk({31'h0, (v > 32'h000000c8) && (v < MAXV)}, 32'h00000001);
      push(5'h09, 60);
      freq_chk(MAXV);
      push(5'h08, 40);
      freq_chk(MAXV);
      push(5'h0b, 40);
      freq_chk(MAXV);
      // Each of run removal, trip and power loss saves and resumes.
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_i) ev <= 3'h1 << k;
         wt(3);
         rd_chk(udfc_pkg::ADDR_SAVED, MAXV);
         wt(60);
         freq_chk(32'h00000000);
         @(posedge clk_i) ev <= 3'h0;
         wt(3);
         freq_chk(MAXV);
      end
      push(5'h0a, 60);
      freq_chk(32'h00000000);
      push(5'h09, 10);
      push(5'h08, 3);
      reg_rd(udfc_pkg::ADDR_FREQ, v);
      wt(40);
      freq_chk(v);
      chk({31'h0, v > 32'h0}, 32'h00000001);
      push(5'h0a, 6);
      push(5'h08, 3);
      reg_rd(udfc_pkg::ADDR_FREQ, d);
      wt(40);
      freq_chk(d);
      chk({31'h0, d < v}, 32'h00000001);
      push(5'h0c, 3);
      rd_chk(udfc_pkg::ADDR_SAVED, 32'h00000000);
      freq_chk(32'h00000000);
      // With no switchover terminal only up and down steer the frequency.
      push(5'h00, 2);
      reg_wr(udfc_pkg::ADDR_FUNC0 + 4'h3, 32'h00000000);
      rd_chk(udfc_pkg::ADDR_STAT, 32'h00000005);
      @(posedge clk_i) ana <= 16'h0100;
      wt(40);
      freq_chk(32'h00000000);
      push(5'h01, 60);
      freq_chk(MAXV);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
